// ===== common/stream_checker_defs.svh
// Purpose: shared constants of the stream pattern checker csr block
// Assumes: included by the package and directly by the design and the testbench
// Notes: offsets are word indices; byte address is four times the index
`ifndef STREAM_CHECKER_DEFS_SVH
`define STREAM_CHECKER_DEFS_SVH

// ----------------------------------------------------------------------
// register word indices
// ----------------------------------------------------------------------
`define IDX_CHECKER_INFO 3'h0
`define IDX_CHECKER_CTRL 3'h1
`define IDX_FAULT_RECORD 3'h5
`define IDX_VIEW_SELECT 3'h6
`define IDX_VIEW_TOTALS 3'h7

// ----------------------------------------------------------------------
// build-time configuration; the first four are reported in the info register
// ----------------------------------------------------------------------
// identity value is arbitrary
`define CORE_IDENTIFIER 16'h00C3
`define CHANNEL_COUNT_CFG 8'h04
`define SYMBOLS_PER_BEAT_CFG 7'h04
`define PACKET_SUPPORT_FLAG 1'h1
`define NUM_CH 4
`define CH_BITS 2
`define SYM_BITS 8
`define DATA_BITS 32

// ----------------------------------------------------------------------
// control field positions and values
// ----------------------------------------------------------------------
`define CTRL_ENABLE_BIT 0
`define CTRL_RATE_LSB 8
`define CTRL_RATE_MSB 16
`define CTRL_CLEAR_BIT 17
`define RATE_FULL 9'h100
`define RATE_RESET 9'h100
`define LFSR_SEED 8'h01
`define LFSR_TAPS 8'hB8
`define CNT_MAX 16'hFFFF

`endif

// ===== common/stream_checker_pkg.sv
// Purpose: types shared by the stream pattern checker csr block
// Assumes: constants come from the defs header
// Notes: all carriers are packed structs
`include "stream_checker_defs.svh"

package stream_checker_pkg;

  // ----------------------------------------------------------------------
  // apb request from the master
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  // ----------------------------------------------------------------------
  // one beat of the incoming stream
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [`DATA_BITS-1:0] data;
    logic [7:0] channel;
    logic sop;
    logic eop;
    logic [7:0] error;
  } stream_beat_s;

  // ----------------------------------------------------------------------
  // whole state of the checker
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic enable;
    logic [8:0] rate;
    logic clear;
    logic [7:0] view_ch;
    logic fault_valid;
    logic [31:0] fault_word;
    logic [7:0] lfsr;
    logic ready;
    logic pready;
    logic [31:0] prdata;
    logic [`NUM_CH-1:0] in_pkt;
    logic [`NUM_CH-1:0][7:0] expect_sym;
    logic [`NUM_CH-1:0][15:0] pkt_cnt;
    logic [`NUM_CH-1:0][15:0] sym_cnt;
    logic [`NUM_CH-1:0][15:0] err_cnt;
  } csr_state_s;

endpackage : stream_checker_pkg

// ===== core/stream_pattern_checker_csr.sv
// Purpose: control, status and per-channel statistics of a stream checker
// Assumes: stream source and apb master run on core_clk
// Notes: apb access phase takes two cycles; outputs come from flops
//
// The APB register port is this design's own decision.
`include "stream_checker_defs.svh"

// Function
// - registers are 32 bits at word indices; indices two to four reserved
// - info bits 15..0 read a fixed identity code
// - info bits 23..16 read the built channel count
// - info bits 30..24 read the built symbols per beat
// - info bit 31 reads one when packets are supported
// - control bit 0 is read/write and enables the checker
// - control bits 16..8 hold rate 0..256, gated by a pseudorandom source
// - rate zero stops, 255 and 256 are full, others give proportional rate
// - while control bit 17 is one all counters and statistics stay cleared
// - fault record reads all zero when no exception was seen
// - fault bit 0 flags a data mismatch
// - fault bit 1 flags a missing start of packet
// - fault bit 2 flags a missing end of packet
// - fault bits 15..8 capture the stream error signal
// - fault bits 31..24 hold the exception's channel
// - select bits 7..0 read/write choose the viewed channel
// - select bits 31..16 read the selected channel's error count
// - totals bits 15..0 read the selected channel's packet count
// - totals bits 31..16 read the selected channel's symbol count
module stream_pattern_checker_csr (
  input wire logic core_clk,
  input wire logic resetn,
  input wire stream_checker_pkg::apb_req_s apb_req,
  output logic [31:0] prdata,
  output logic pready,
  input wire stream_checker_pkg::stream_beat_s beat,
  output logic beat_ready
);

  stream_checker_pkg::csr_state_s s_r;
  stream_checker_pkg::csr_state_s s_nxt;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // saturating add keeps totals pinned at the top instead of wrapping
  function automatic logic [15:0] sat_add(input logic [15:0] v,
                                          input logic [15:0] inc);
    logic [16:0] sum;
    sum = {1'b0, v} + {1'b0, inc};
    sat_add = sum[16] ? `CNT_MAX : sum[15:0];
  endfunction : sat_add

  logic [31:0] info_word;
  logic [31:0] ctrl_word;
  logic [31:0] select_word;
  logic [31:0] totals_word;
  logic [`CH_BITS-1:0] view_idx;
  logic view_ok;

  // fixed build description
  assign info_word = {`PACKET_SUPPORT_FLAG,
                      `SYMBOLS_PER_BEAT_CFG,
                      `CHANNEL_COUNT_CFG,
                      `CORE_IDENTIFIER};

  // control read-back, reserved bits zero
  assign ctrl_word = {14'h0000, s_r.clear, s_r.rate, 7'h00,
                      s_r.enable};

  // a selector past the last channel shows zero totals
  assign view_ok = ({1'b0, s_r.view_ch} < 9'(`NUM_CH));
  assign view_idx = s_r.view_ch[`CH_BITS-1:0];
  assign select_word = {view_ok ? s_r.err_cnt[view_idx] : 16'h0000,
                        8'h00, s_r.view_ch};
  assign totals_word = view_ok ? {s_r.sym_cnt[view_idx],
                                  s_r.pkt_cnt[view_idx]}
                               : 32'h0000_0000;

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  logic [2:0] word_idx;
  logic in_range;
  logic access;
  logic commit;
  logic [31:0] rd_mux;

  assign word_idx = apb_req.paddr[4:2];
  assign in_range = (apb_req.paddr[11:5] == 7'h00);
  assign access = apb_req.psel && apb_req.penable;
  assign commit = access && s_r.pready;

  // read mux; holes and addresses beyond the map read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (!in_range) begin
      rd_mux = 32'h0000_0000;
    end else if (word_idx == `IDX_CHECKER_INFO) begin
      rd_mux = info_word;
    end else if (word_idx == `IDX_CHECKER_CTRL) begin
      rd_mux = ctrl_word;
    end else if (word_idx == `IDX_FAULT_RECORD) begin
      rd_mux = s_r.fault_valid ? s_r.fault_word : 32'h0000_0000;
    end else if (word_idx == `IDX_VIEW_SELECT) begin
      rd_mux = select_word;
    end else if (word_idx == `IDX_VIEW_TOTALS) begin
      rd_mux = totals_word;
    end
  end

  // ----------------------------------------------------------------------
  // stream checking terms
  // ----------------------------------------------------------------------
  logic accept;
  logic ch_ok;
  logic [`CH_BITS-1:0] ch;
  logic [7:0] base_sym;
  logic data_bad;
  logic sop_missing;
  logic eop_missing;
  logic signalled;
  logic rate_pass;

  assign accept = beat.valid && s_r.ready;
  assign ch_ok = ({1'b0, beat.channel} < 9'(`NUM_CH));
  assign ch = beat.channel[`CH_BITS-1:0];
  // pattern restarts at zero on each packet start
  assign base_sym = (`PACKET_SUPPORT_FLAG && beat.sop) ? 8'h00
                                                       : s_r.expect_sym[ch];

  // each symbol of a beat is expected to step by one
  always_comb begin
    data_bad = 1'b0;
    for (int k = 0; k < 4; k++) begin
      if (beat.data[k*`SYM_BITS +: `SYM_BITS] != 8'(base_sym + 8'(k))) begin
        data_bad = 1'b1;
      end
    end
  end

  // boundary faults only exist when packets are built in
  assign sop_missing = `PACKET_SUPPORT_FLAG && !s_r.in_pkt[ch] &&
                       !beat.sop;
  assign eop_missing = `PACKET_SUPPORT_FLAG && s_r.in_pkt[ch] &&
                       beat.sop;
  assign signalled = (beat.error != 8'h00);

  // lfsr runs 1..255, so lfsr-1 covers 0..254 against the rate value;
  // rate 255 therefore already passes every cycle like full, a cheap trade for 8 bits
  assign rate_pass = (s_r.rate >= `RATE_FULL) ||
                     ({1'b0, 8'(s_r.lfsr - 8'h01)} < s_r.rate);

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.pready = 1'b0;

    // first access cycle loads read data, second completes the transfer
    if (access && !s_r.pready) begin
      s_nxt.pready = 1'b1;
      s_nxt.prdata = rd_mux;
    end

    // writes land only at the completing edge
    if (commit && apb_req.pwrite && in_range) begin
      if (word_idx == `IDX_CHECKER_CTRL) begin
        s_nxt.enable = apb_req.pwdata[`CTRL_ENABLE_BIT];
        // values above full rate are clamped to full rate
        s_nxt.rate = (apb_req.pwdata[`CTRL_RATE_MSB:`CTRL_RATE_LSB] >
                      `RATE_FULL) ? `RATE_FULL :
                     apb_req.pwdata[`CTRL_RATE_MSB:`CTRL_RATE_LSB];
        s_nxt.clear = apb_req.pwdata[`CTRL_CLEAR_BIT];
      end else if (word_idx == `IDX_VIEW_SELECT) begin
        s_nxt.view_ch = apb_req.pwdata[7:0];
      end
    end

    // pseudorandom source for rate gating
    s_nxt.lfsr = s_r.lfsr[0] ? ((s_r.lfsr >> 1) ^ `LFSR_TAPS)
                             : (s_r.lfsr >> 1);
    s_nxt.ready = s_r.enable && !s_r.clear && (s_r.rate != 9'h000) &&
                  rate_pass;

    // accepted beat updates its channel
    if (accept && ch_ok) begin
      s_nxt.expect_sym[ch] = 8'(base_sym + 8'(`SYMBOLS_PER_BEAT_CFG));
      s_nxt.sym_cnt[ch] = sat_add(s_r.sym_cnt[ch],
                                  16'(`SYMBOLS_PER_BEAT_CFG));
      if (data_bad) begin
        s_nxt.err_cnt[ch] = sat_add(s_r.err_cnt[ch], 16'h0001);
      end
      if (`PACKET_SUPPORT_FLAG) begin
        s_nxt.in_pkt[ch] = !beat.eop;
        if (beat.eop) begin
          s_nxt.pkt_cnt[ch] = sat_add(s_r.pkt_cnt[ch], 16'h0001);
        end
      end else begin
        s_nxt.pkt_cnt[ch] = sat_add(s_r.pkt_cnt[ch], 16'h0001);
      end
      // only the first exception is recorded until the next clear
      if (!s_r.fault_valid &&
          (data_bad || sop_missing || eop_missing || signalled)) begin
        s_nxt.fault_valid = 1'b1;
        s_nxt.fault_word = {beat.channel,
                            8'h00,
                            beat.error,
                            5'h00,
                            eop_missing,
                            sop_missing,
                            data_bad};
      end
    end

    // the clear holds the statistics, packet state and fault record at zero for as long as it is set
    if (s_r.clear) begin
      s_nxt.in_pkt = '0;
      s_nxt.expect_sym = '0;
      s_nxt.pkt_cnt = '0;
      s_nxt.sym_cnt = '0;
      s_nxt.err_cnt = '0;
      s_nxt.fault_valid = 1'b0;
      s_nxt.fault_word = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s_r <= '0;
      s_r.rate <= `RATE_RESET;
      s_r.lfsr <= `LFSR_SEED;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from flops
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign beat_ready = s_r.ready;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  logic rd_commit;
  assign rd_commit = commit && !apb_req.pwrite && in_range;

  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence

  sequence s_access;
    apb_req.psel && apb_req.penable && !s_r.pready;
  endsequence

  sequence s_ctrl_write;
    commit && apb_req.pwrite && in_range &&
      (word_idx == `IDX_CHECKER_CTRL);
  endsequence

  sequence s_select_write;
    commit && apb_req.pwrite && in_range &&
      (word_idx == `IDX_VIEW_SELECT);
  endsequence

  a_apb_answer_time: assert property (
    s_setup ##1 s_access |=> pready)
    else $error("apb answer not one cycle after access start");

  a_info_readback: assert property (
    rd_commit && (word_idx == `IDX_CHECKER_INFO) |->
      (prdata[15:0] == `CORE_IDENTIFIER) && (prdata[31] == 1'b1))
    else $error("info register read wrong");

  a_reserved_zero: assert property (
    rd_commit && (word_idx >= 3'h2) && (word_idx <= 3'h4) |->
      (prdata == 32'h0000_0000))
    else $error("reserved offset read nonzero");

  a_enable_write: assert property (
    s_ctrl_write |=> (s_r.enable == $past(apb_req.pwdata[0])))
    else $error("enable bit not taken from write");

  a_disabled_stall: assert property (
    !s_r.enable |=> !beat_ready)
    else $error("ready while checker disabled");

  a_rate_zero_halt: assert property (
    (s_r.rate == 9'h000) |=> !beat_ready)
    else $error("ready while rate is zero");

  a_rate_full_run: assert property (
    s_r.enable && !s_r.clear && (s_r.rate == `RATE_FULL) |=> beat_ready)
    else $error("full rate did not give ready");

  a_clear_holds: assert property (
    s_r.clear ##1 s_r.clear |-> (s_r.pkt_cnt == '0) &&
      (s_r.err_cnt == '0) && !s_r.fault_valid && !beat_ready)
    else $error("statistics not held clear");

  a_no_fault_zero: assert property (
    rd_commit && (word_idx == `IDX_FAULT_RECORD) &&
      !$past(s_r.fault_valid) |-> (prdata == 32'h0000_0000))
    else $error("fault record nonzero without exception");

  a_missing_sop: assert property (
    accept && ch_ok && sop_missing && !s_r.fault_valid && !s_r.clear
      |=> s_r.fault_valid && s_r.fault_word[1] &&
          (s_r.fault_word[31:24] == $past(beat.channel)))
    else $error("missing start of packet not recorded");

  a_sym_saturate: assert property (
    (s_r.sym_cnt[0] == `CNT_MAX) && !s_r.clear |=>
      (s_r.sym_cnt[0] == `CNT_MAX))
    else $error("symbol total wrapped");

  a_info_channels: assert property (
    rd_commit && (word_idx == `IDX_CHECKER_INFO) |->
      (prdata[23:16] == `CHANNEL_COUNT_CFG))
    else $error("info channel count read wrong");

  a_info_symbols: assert property (
    rd_commit && (word_idx == `IDX_CHECKER_INFO) |->
      (prdata[30:24] == `SYMBOLS_PER_BEAT_CFG))
    else $error("info symbol count read wrong");

  a_ctrl_reserved: assert property (
    rd_commit && (word_idx == `IDX_CHECKER_CTRL) |->
      (prdata[7:1] == 7'h00) && (prdata[31:18] == 14'h0000))
    else $error("control reserved bits read nonzero");

  a_rate_write: assert property (
    commit && apb_req.pwrite && in_range &&
      (word_idx == `IDX_CHECKER_CTRL) &&
      (apb_req.pwdata[`CTRL_RATE_MSB:`CTRL_RATE_LSB] <= `RATE_FULL) |=>
      (s_r.rate == $past(apb_req.pwdata[`CTRL_RATE_MSB:`CTRL_RATE_LSB])))
    else $error("rate value not taken from write");

  a_rate_clamp: assert property (
    commit && apb_req.pwrite && in_range &&
      (word_idx == `IDX_CHECKER_CTRL) &&
      (apb_req.pwdata[`CTRL_RATE_MSB:`CTRL_RATE_LSB] > `RATE_FULL) |=>
      (s_r.rate == `RATE_FULL))
    else $error("rate above full not clamped");

  a_clear_write: assert property (
    s_ctrl_write |=> (s_r.clear == $past(apb_req.pwdata[`CTRL_CLEAR_BIT])))
    else $error("clear bit not taken from write");

  a_clear_stall: assert property (
    s_r.clear |=> !beat_ready)
    else $error("ready while clear is held");

  a_select_write: assert property (
    s_select_write |=> (s_r.view_ch == $past(apb_req.pwdata[7:0])))
    else $error("selector not taken from write");

  a_select_read: assert property (
    rd_commit && (word_idx == `IDX_VIEW_SELECT) |->
      (prdata[7:0] == s_r.view_ch) && (prdata[15:8] == 8'h00))
    else $error("selector read-back wrong");

  a_missing_eop: assert property (
    accept && ch_ok && eop_missing && !s_r.fault_valid && !s_r.clear
      |=> s_r.fault_valid && s_r.fault_word[2])
    else $error("missing end of packet not recorded");

  a_data_mismatch: assert property (
    accept && ch_ok && data_bad && !s_r.fault_valid && !s_r.clear
      |=> s_r.fault_valid && s_r.fault_word[0])
    else $error("data mismatch not recorded");

  a_error_capture: assert property (
    accept && ch_ok && signalled && !s_r.fault_valid && !s_r.clear
      |=> (s_r.fault_word[15:8] == $past(beat.error)))
    else $error("stream error value not captured");

  a_fault_hold: assert property (
    s_r.fault_valid && !s_r.clear |=>
      s_r.fault_valid && $stable(s_r.fault_word))
    else $error("recorded exception changed");

  a_fault_read: assert property (
    rd_commit && (word_idx == `IDX_FAULT_RECORD) &&
      $past(s_r.fault_valid) |-> (prdata == $past(s_r.fault_word)))
    else $error("fault record read wrong");

endmodule : stream_pattern_checker_csr

// ===== tb/stream_source_model.sv
// Purpose: stream source feeding the checker with the step-by-one pattern
// Assumes: beat taken at a rising edge where valid and beat_ready are high
// Notes: after an accept timeout every later send returns at once
module stream_source_model (
  input wire logic core_clk,
  input wire logic beat_ready,
  output stream_checker_pkg::stream_beat_s beat
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------------
  // running symbol per channel and accept timeouts
  // ----------------------------------------------------------------------
  logic [7:0] run [4];
  int miss;
  initial begin
    beat = '0;
    miss = 0;
    foreach (run[i]) run[i] = 8'h00;
  end
  // restart every channel's pattern, as the checker does on a clear
  task automatic flush();
    foreach (run[i]) run[i] = 8'h00;
  endtask : flush
  // hold the beat until an edge samples beat_ready high; flip corrupts
  task automatic send(input logic [7:0] ch, input logic sop,
                      input logic eop, input logic [7:0] err,
                      input logic [7:0] flip);
    logic [7:0] b;
    int n;
    if (miss != 0) return;
    b = sop ? 8'h00 : run[ch[1:0]];
    beat.valid <= 1'b1;
    beat.channel <= ch;
    beat.sop <= sop;
    beat.eop <= eop;
    beat.error <= err;
    beat.data <= {b + 8'h03, b + 8'h02, b + 8'h01, b ^ flip};
    run[ch[1:0]] = b + 8'h04;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (beat_ready !== 1'b1 && n < 100);
    if (beat_ready !== 1'b1) miss++;
  endtask : send
  // released data is inverted so a stale beat never looks valid
  task automatic idle();
    beat.valid <= 1'b0;
    beat.sop <= 1'b0;
    beat.eop <= 1'b0;
    beat.data <= ~beat.data;
    @(posedge core_clk);
  endtask : idle
endmodule : stream_source_model

// ===== tb/tb_stream_pattern_checker_csr.sv
// Purpose: self-checking bench of the checker's registers and statistics
// Assumes: apb answers in its own time; the source model drives the stream
// Notes: saturation run takes about 16400 cycles
`include "stream_checker_defs.svh"
module tb_stream_pattern_checker_csr;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------------
  // clock, wiring and counters
  // ----------------------------------------------------------------------
  logic core_clk;
  logic resetn;
  stream_checker_pkg::apb_req_s apb_req;
  logic [31:0] prdata;
  logic pready;
  stream_checker_pkg::stream_beat_s beat;
  logic beat_ready;
  logic [31:0] rd;
  int n_mismatch;
  int n_tests;
  always #2 core_clk = ~core_clk;
  stream_pattern_checker_csr stream_pattern_checker_csr_i (
    .core_clk(core_clk), .resetn(resetn), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .beat(beat),
    .beat_ready(beat_ready));
  stream_source_model stream_source_model_i (
    .core_clk(core_clk), .beat_ready(beat_ready), .beat(beat));
  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one transfer held until pready is sampled high, then released
  task automatic apb(input logic wr, input logic [11:0] addr,
                     input logic [31:0] wd);
    int n;
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= wr;
    apb_req.paddr <= addr;
    apb_req.pwdata <= wd;
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      n_mismatch++;
      results();
    end
    rd = prdata;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic wr(input logic [2:0] idx, input logic [31:0] d);
    apb(1'b1, {7'h00, idx, 2'b00}, d);
  endtask : wr
  task automatic rdc(input logic [2:0] idx, input logic [31:0] exp);
    apb(1'b0, {7'h00, idx, 2'b00}, 32'h00000000);
    chk(rd, exp);
  endtask : rdc
  // counts edges with beat_ready high out of n
  task automatic count_ready(input int n, output int ones);
    ones = 0;
    repeat (n) begin
      @(posedge core_clk);
      if (beat_ready === 1'b1) ones++;
    end
  endtask : count_ready
  // clear pulse: fault record must read zero while held, then released
  task automatic clr();
    wr(3'h1, 32'h00030001);
    rdc(3'h5, 32'h00000000);
    wr(3'h1, 32'h00010001);
    stream_source_model_i.flush();
  endtask : clr
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_info();
    logic [31:0] info;
    info = {`PACKET_SUPPORT_FLAG, `SYMBOLS_PER_BEAT_CFG, `CHANNEL_COUNT_CFG,
            `CORE_IDENTIFIER};
    rdc(3'h0, info);
    wr(3'h0, 32'hFFFFFFFF);
    rdc(3'h0, info);
    for (int i = 2; i <= 4; i++) begin
      wr(3'(i), 32'hFFFFFFFF);
      rdc(3'(i), 32'h00000000);
    end
    apb(1'b1, 12'h100, 32'hFFFFFFFF);
    apb(1'b0, 12'h100, 32'h00000000);
    chk(rd, 32'h00000000);
    $display("test info done");
  endtask : t_info
  task automatic t_ctrl();
    int ones;
    rdc(3'h1, 32'h00010000);
    wr(3'h1, 32'hFFFD00FF);
    rdc(3'h1, 32'h00010001);
    wr(3'h1, 32'h00000001);
    count_ready(40, ones);
    chk(32'(ones), 32'h00000000);
    wr(3'h1, 32'h00010001);
    repeat (4) @(posedge core_clk);
    count_ready(20, ones);
    chk(32'(ones), 32'h00000014);
    wr(3'h1, 32'h00008001);
    count_ready(200, ones);
    chk(32'(ones > 50 && ones < 150), 32'h00000001);
    rdc(3'h1, 32'h00008001);
    wr(3'h1, 32'h0001FF01);
    rdc(3'h1, 32'h00010001);
    wr(3'h1, 32'h00010001);
    wr(3'h6, 32'hFFFFFFFF);
    rdc(3'h6, 32'h000000FF);
    $display("test ctrl done");
  endtask : t_ctrl
  task automatic t_counts();
    stream_source_model_i.send(8'h01, 1'b1, 1'b0, 8'h00, 8'h00);
    stream_source_model_i.send(8'h01, 1'b0, 1'b0, 8'h00, 8'h00);
    stream_source_model_i.send(8'h01, 1'b0, 1'b1, 8'h00, 8'h00);
    stream_source_model_i.idle();
    wr(3'h6, 32'h00000001);
    rdc(3'h6, 32'h00000001);
    rdc(3'h7, 32'h000C0001);
    rdc(3'h5, 32'h00000000);
    stream_source_model_i.send(8'h02, 1'b1, 1'b0, 8'h00, 8'h10);
    stream_source_model_i.idle();
    wr(3'h6, 32'h00000002);
    rdc(3'h6, 32'h00010002);
    rdc(3'h5, 32'h02000001);
    clr();
    rdc(3'h6, 32'h00000002);
    $display("test counts done");
  endtask : t_counts
  task automatic t_faults();
    stream_source_model_i.send(8'h03, 1'b0, 1'b0, 8'h00, 8'h00);
    stream_source_model_i.idle();
    rdc(3'h5, 32'h03000002);
    clr();
    stream_source_model_i.send(8'h00, 1'b1, 1'b0, 8'h00, 8'h00);
    stream_source_model_i.send(8'h00, 1'b1, 1'b0, 8'h00, 8'h00);
    stream_source_model_i.idle();
    rdc(3'h5, 32'h00000004);
    clr();
    stream_source_model_i.send(8'h01, 1'b1, 1'b0, 8'h5A, 8'h00);
    stream_source_model_i.idle();
    rdc(3'h5, 32'h01005A00);
    $display("test faults done");
  endtask : t_faults
  task automatic t_sat();
    clr();
    stream_source_model_i.send(8'h00, 1'b1, 1'b0, 8'h00, 8'h00);
    repeat (16400) stream_source_model_i.send(8'h00, 1'b0, 1'b0, 8'h00,
                                              8'h00);
    stream_source_model_i.idle();
    wr(3'h6, 32'h00000000);
    rdc(3'h7, 32'hFFFF0000);
    chk(32'(stream_source_model_i.miss), 32'h00000000);
    $display("test saturation done");
  endtask : t_sat
  // mid-run reset must drop control, selector and a recorded exception
  task automatic t_reset();
    wr(3'h6, 32'h00000003);
    stream_source_model_i.send(8'h02, 1'b0, 1'b0, 8'h00, 8'h00);
    stream_source_model_i.idle();
    rdc(3'h5, 32'h02000002);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    rdc(3'h1, 32'h00010000);
    rdc(3'h6, 32'h00000000);
    rdc(3'h5, 32'h00000000);
    $display("test reset done");
  endtask : t_reset
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    resetn = 1'b0;
    apb_req = '0;
    n_mismatch = 0;
    n_tests = 0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    t_info();
    t_ctrl();
    t_counts();
    t_faults();
    t_sat();
    t_reset();
    results();
  end
endmodule : tb_stream_pattern_checker_csr
